/* File: src/cache_pkg.sv */
// Shared constants, bus size codes and carrier structs for the cache and
// translation unit. Assumes one processor clock for core and bus sides.
package cache_pkg;

	// Address and data widths
	localparam int VA_W       = 32;
	localparam int PA_W       = 32;
	localparam int DATA_W     = 32;
	localparam int PFN_W      = 23;
	localparam int PAGE_OFS_W = 9;
	localparam int LINE_OFS_W = 2;
	localparam int LINE_BYTES = 4;
	localparam int MASK_W     = 8;

	// Documented sizes
	localparam int CACHE_BYTES_DEF = 65536;
	localparam int TB_REGION_DEF   = 512;

	// Byte mask of a longword write inside a quadword slot
	localparam logic [MASK_W-1:0] LONG_MASK = 8'h0F;
	// Value of cleared storage and idle command fields after reset
	localparam logic [DATA_W-1:0] DATA_RST  = 32'h0000_0000;

	// Transaction sizes on the memory_interconnect_bus
	typedef enum logic [2:0] {
		SZ_RD_LONG  = 3'h0,
		SZ_RD_OCTA  = 3'h1,
		SZ_RD_HEX   = 3'h2,
		SZ_WR_LONG  = 3'h4,
		SZ_WR_MQUAD = 3'h5,
		SZ_WR_OCTA  = 3'h6
	} busSize_t;

	// Miss tracker states, one-hot
	typedef enum logic [1:0] {
		MS_IDLE = 2'h1,
		MS_WAIT = 2'h2
	} missState_t;

	// Processor request
	typedef struct packed {
		logic              write;
		logic [VA_W-1:0]   vaddr;
		logic [DATA_W-1:0] wdata;
	} procReq_t;

	// Translation load from the microcode side
	typedef struct packed {
		logic              valid;
		logic [VA_W-1:0]   vaddr;
		logic [PFN_W-1:0]  pfn;
	} tbLoad_t;

	// Command/address transaction towards memory
	typedef struct packed {
		busSize_t          size;
		logic [PA_W-1:0]   addr;
		logic [DATA_W-1:0] data;
		logic [MASK_W-1:0] mask;
	} busCmd_t;

endpackage

/* File: src/store_array.sv */
// Flip-flop storage array with one write port and one combinational read.
// Assumes writes are gated by the caller; all entries clear on reset.
`timescale 1ns/10ps
`default_nettype none
module store_array #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)(
	// Clock and reset
	input  wire logic                     clock,
	input  wire logic                     reset_n,
	input  wire logic                     ce,
	// Write port
	input  wire logic                     wrEn,
	input  wire logic [$clog2(DEPTH)-1:0] wrIdx,
	input  wire logic [WIDTH-1:0]         wrData,
	// Read port
	input  wire logic [$clog2(DEPTH)-1:0] rdIdx,
	output logic      [WIDTH-1:0]         rdData
);

	// Depth must be a power of two so every index names a slot
	if (DEPTH < 2 || (1 << $clog2(DEPTH)) != DEPTH || WIDTH < 1) begin : g_chk
		$error("store_array: unsupported size");
	end

	logic [WIDTH-1:0] mem_q [DEPTH]; // Storage cells

	// Write port; reset clears every bit of each word
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (ce && wrEn) begin
			mem_q[wrIdx] <= wrData;
		end
	end

	// Read shows the old word during a write to the same slot
	assign rdData = mem_q[rdIdx];

endmodule
`default_nettype wire

/* File: src/cache_translation_unit.sv */
// Cache unit: translation buffer, direct-mapped write-through data cache
// and the memory_interconnect_bus interface. Assumes the bus shares clock.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - 64 KB physical direct-mapped write-through cache
// - 1 KB translations: tag and data arrays
// - 512 process slots, 512 system slots
// - Hit needs tag match and valid bit
// - Physical address is PFN over bits 8:0
// - Read hit answers from cache, no bus
// - Read miss fetches, forwards and fills
// - Miss builds command/address from physical address
// - Hits still served while miss outstanding
// - Returned data written into cache store unless a write hit that slot during the miss
// - Reads are issued as longword only (SZ_RD_LONG)
// - Writes are issued as longword only (SZ_WR_LONG, LONG_MASK)
module cache_translation_unit import cache_pkg::*; #(
	parameter int CACHE_BYTES       = CACHE_BYTES_DEF,
	parameter int TB_REGION_ENTRIES = TB_REGION_DEF
)(
	// Clock, reset, enable
	input  wire logic              clock,
	input  wire logic              reset_n,
	input  wire logic              ce,
	// Processor request
	input  wire logic              reqValid,
	input  wire procReq_t          reqIn,
	// Translation load
	input  wire logic              tbLoadEn,
	input  wire tbLoad_t           tbLoadIn,
	// Processor answer
	output logic                   respValid,
	output logic      [DATA_W-1:0] respData,
	output logic                   respFill,
	output logic                   writeDone,
	output logic                   retry,
	output logic                   microtrap,
	// memory_interconnect_bus side
	output logic                   busCmdValid,
	output busCmd_t                busCmd,
	input  wire logic              busCmdReady,
	input  wire logic              busFillValid,
	input  wire logic [DATA_W-1:0] busFillData
);

	localparam int LINES  = CACHE_BYTES / LINE_BYTES;
	localparam int CIDX_W = $clog2(LINES);
	localparam int CTAG_W = PA_W - CIDX_W - LINE_OFS_W;
	localparam int TIDX_W = $clog2(TB_REGION_ENTRIES);
	localparam int TTAG_W = VA_W - 1 - PAGE_OFS_W - TIDX_W;

	// Sizes must fit the address split
	if (CTAG_W < 1 || TTAG_W < 1 || PFN_W + PAGE_OFS_W != PA_W) begin : g_chk
		$error("cache_translation_unit: unsupported size");
	end

	// Lookup wires
	logic [TIDX_W:0]        tbRdIdx;   // Region bit over slot index
	logic [TIDX_W:0]        tbWrIdx;   // Load slot
	logic [TTAG_W:0]        tbTagRd;   // Valid over tag
	logic [PFN_W-1:0]       tbPfnRd;   // Stored frame number
	logic                   tbHit;     // Translation usable
	logic [PA_W-1:0]        physAddr;  // Translated address
	logic [CIDX_W-1:0]      cIdx;      // Cache slot of request
	logic [CTAG_W:0]        cTagRd;    // Valid over tag
	logic [DATA_W-1:0]      cDataRd;   // Cached longword
	logic                   cacheHit;  // Data present
	// Decisions
	logic                   fillGo;    // Memory data arriving
	logic                   cmdBusy;   // Command slot still held
	logic                   reqGo;     // Request may use the cache
	logic                   trapGo;
	logic                   rdHitGo;
	logic                   rdMissGo;
	logic                   wrGo;
	logic                   retryGo;
	logic                   cWrEn;     // Cache write port
	logic [CIDX_W-1:0]      cWrIdx;
	logic [CTAG_W:0]        cWrTag;
	logic [DATA_W-1:0]      cWrData;
	// State
	missState_t             missState_q;
	logic [PA_W-1:0]        missAddr_q;   // Address awaiting data
	logic                   missStale_q;  // Newer write seen for it
	logic                   cmdValid_q;
	busCmd_t                cmd_q;
	logic                   respValid_q;
	logic [DATA_W-1:0]      respData_q;
	logic                   respFill_q;
	logic                   writeDone_q;
	logic                   retry_q;
	logic                   trap_q;

	// Translation index: top bit picks system half, rest is slot
	assign tbRdIdx = {reqIn.vaddr[VA_W-1], reqIn.vaddr[PAGE_OFS_W +: TIDX_W]};
	assign tbWrIdx = {tbLoadIn.vaddr[VA_W-1], tbLoadIn.vaddr[PAGE_OFS_W +: TIDX_W]};

	// Translation tag store
	store_array #(.WIDTH(TTAG_W + 1), .DEPTH(2 * TB_REGION_ENTRIES)) u_tbTag (
		.clock  (clock),
		.reset_n(reset_n),
		.ce     (ce),
		.wrEn   (tbLoadEn),
		.wrIdx  (tbWrIdx),
		.wrData ({tbLoadIn.valid, tbLoadIn.vaddr[VA_W-2 -: TTAG_W]}),
		.rdIdx  (tbRdIdx),
		.rdData (tbTagRd)
	);

	// Translation data store, kept apart from tags
	store_array #(.WIDTH(PFN_W), .DEPTH(2 * TB_REGION_ENTRIES)) u_tbData (
		.clock  (clock),
		.reset_n(reset_n),
		.ce     (ce),
		.wrEn   (tbLoadEn),
		.wrIdx  (tbWrIdx),
		.wrData (tbLoadIn.pfn),
		.rdIdx  (tbRdIdx),
		.rdData (tbPfnRd)
	);

	// Hit needs matching tag and a set valid bit
	assign tbHit = tbTagRd[TTAG_W] && (tbTagRd[TTAG_W-1:0] == reqIn.vaddr[VA_W-2 -: TTAG_W]);
	// Frame number joined above the untranslated page offset
	assign physAddr = {tbPfnRd, reqIn.vaddr[PAGE_OFS_W-1:0]};
	assign cIdx     = physAddr[LINE_OFS_W +: CIDX_W];

	// Cache tag store, one slot per physical index
	store_array #(.WIDTH(CTAG_W + 1), .DEPTH(LINES)) u_cTag (
		.clock  (clock),
		.reset_n(reset_n),
		.ce     (ce),
		.wrEn   (cWrEn),
		.wrIdx  (cWrIdx),
		.wrData (cWrTag),
		.rdIdx  (cIdx),
		.rdData (cTagRd)
	);

	// Cache data store
	store_array #(.WIDTH(DATA_W), .DEPTH(LINES)) u_cData (
		.clock  (clock),
		.reset_n(reset_n),
		.ce     (ce),
		.wrEn   (cWrEn),
		.wrIdx  (cWrIdx),
		.wrData (cWrData),
		.rdIdx  (cIdx),
		.rdData (cDataRd)
	);

	assign cacheHit = cTagRd[CTAG_W] && (cTagRd[CTAG_W-1:0] == physAddr[PA_W-1 -: CTAG_W]);

	// Request steering; a fill owns the cache and answer path that cycle
	assign fillGo   = ce && busFillValid && (missState_q == MS_WAIT);
	assign cmdBusy  = cmdValid_q && !busCmdReady;
	assign reqGo    = ce && reqValid && !fillGo;
	assign trapGo   = reqGo && !tbHit;
	assign rdHitGo  = reqGo && tbHit && !reqIn.write && cacheHit;
	assign rdMissGo = reqGo && tbHit && !reqIn.write && !cacheHit
		&& (missState_q == MS_IDLE) && !cmdBusy;
	assign wrGo     = reqGo && tbHit && reqIn.write && !cmdBusy;
	assign retryGo  = ce && reqValid && !trapGo && !rdHitGo && !rdMissGo && !wrGo;

	// Cache write port: fill first, then a write-through hit
	always_comb begin
		if (fillGo) begin
			cWrEn   = !missStale_q;
			cWrIdx  = missAddr_q[LINE_OFS_W +: CIDX_W];
			cWrTag  = {1'b1, missAddr_q[PA_W-1 -: CTAG_W]};
			cWrData = busFillData;
		end else begin
			cWrEn   = wrGo && cacheHit;
			cWrIdx  = cIdx;
			cWrTag  = {1'b1, physAddr[PA_W-1 -: CTAG_W]};
			cWrData = reqIn.wdata;
		end
	end

	// Miss tracker: one outstanding read; other requests keep flowing
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			missState_q <= MS_IDLE;
			missAddr_q  <= '0;
			missStale_q <= 1'b0;
		end else if (ce) begin
			case (missState_q)
				MS_IDLE: begin
					if (rdMissGo) begin
						missState_q <= MS_WAIT;
						missAddr_q  <= physAddr;
						missStale_q <= 1'b0;
					end
				end
				MS_WAIT: begin
					// A write to the same slot would be undone by old fill data
					if (wrGo && (cIdx == missAddr_q[LINE_OFS_W +: CIDX_W])) begin
						missStale_q <= 1'b1;
					end
					if (fillGo) begin
						missState_q <= MS_IDLE;
					end
				end
				default: begin
					missState_q <= MS_IDLE;
				end
			endcase
		end
	end

	// Command slot; held until the bus takes it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cmdValid_q <= 1'b0;
			cmd_q      <= '{size: SZ_RD_LONG, addr: '0, data: DATA_RST, mask: '0};
		end else if (ce) begin
			if (rdMissGo) begin
				cmdValid_q <= 1'b1;
				cmd_q      <= '{size: SZ_RD_LONG, addr: physAddr, data: DATA_RST, mask: '0};
			end else if (wrGo) begin
				cmdValid_q <= 1'b1;
				cmd_q      <= '{size: SZ_WR_LONG, addr: physAddr, data: reqIn.wdata, mask: LONG_MASK};
			end else if (busCmdReady) begin
				cmdValid_q <= 1'b0;
			end
		end
	end

	// Processor answers, one-cycle pulses
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			respValid_q <= 1'b0;
			respData_q  <= DATA_RST;
			respFill_q  <= 1'b0;
			writeDone_q <= 1'b0;
			retry_q     <= 1'b0;
			trap_q      <= 1'b0;
		end else if (ce) begin
			respValid_q <= rdHitGo || fillGo;
			respFill_q  <= fillGo;
			if (fillGo) begin
				respData_q <= busFillData;
			end else if (rdHitGo) begin
				respData_q <= cDataRd;
			end
			writeDone_q <= wrGo;
			retry_q     <= retryGo;
			trap_q      <= trapGo;
		end
	end

	assign respValid   = respValid_q;
	assign respData    = respData_q;
	assign respFill    = respFill_q;
	assign writeDone   = writeDone_q;
	assign retry       = retry_q;
	assign microtrap   = trap_q;
	assign busCmdValid = cmdValid_q;
	assign busCmd      = cmd_q;

	// Checks
	sequence s_readMiss;
		rdMissGo;
	endsequence
	sequence s_fillArrive;
		fillGo;
	endsequence

	property p_hitAnswers;
		@(posedge clock) disable iff (!reset_n)
		rdHitGo |=> respValid_q && !respFill_q && (respData_q == $past(cDataRd));
	endproperty
	a_hitAnswers: assert property (p_hitAnswers) else $error("hit not answered");

	property p_hitNoBus;
		@(posedge clock) disable iff (!reset_n)
		rdHitGo && !cmdValid_q |=> !cmdValid_q;
	endproperty
	a_hitNoBus: assert property (p_hitNoBus) else $error("hit went to bus");

	property p_missCmd;
		@(posedge clock) disable iff (!reset_n)
		s_readMiss |=> cmdValid_q && cmd_q.size == SZ_RD_LONG && cmd_q.addr == $past(physAddr);
	endproperty
	a_missCmd: assert property (p_missCmd) else $error("miss command wrong");

	property p_missWaits;
		@(posedge clock) disable iff (!reset_n)
		s_readMiss |=> missState_q == MS_WAIT && missAddr_q == $past(physAddr);
	endproperty
	a_missWaits: assert property (p_missWaits) else $error("miss not tracked");

	property p_fillForward;
		@(posedge clock) disable iff (!reset_n)
		s_fillArrive |=> respValid_q && respFill_q && respData_q == $past(busFillData)
			&& missState_q == MS_IDLE;
	endproperty
	a_fillForward: assert property (p_fillForward) else $error("fill not forwarded");

	property p_fillInstall;
		@(posedge clock) disable iff (!reset_n)
		s_fillArrive and !missStale_q |-> cWrEn && cWrIdx == missAddr_q[LINE_OFS_W +: CIDX_W];
	endproperty
	a_fillInstall: assert property (p_fillInstall) else $error("fill not installed");

	property p_trap;
		@(posedge clock) disable iff (!reset_n)
		ce && reqValid && !fillGo && !tbHit |=> trap_q && !respValid_q && !writeDone_q;
	endproperty
	a_trap: assert property (p_trap) else $error("no microtrap");

	property p_writeThrough;
		@(posedge clock) disable iff (!reset_n)
		wrGo |=> cmdValid_q && cmd_q.size == SZ_WR_LONG && cmd_q.data == $past(reqIn.wdata)
			&& writeDone_q;
	endproperty
	a_writeThrough: assert property (p_writeThrough) else $error("write not sent");

	property p_servedWhileWait;
		@(posedge clock) disable iff (!reset_n)
		missState_q == MS_WAIT && rdHitGo |=> respValid_q && !retry_q;
	endproperty
	a_servedWhileWait: assert property (p_servedWhileWait) else $error("hit blocked");

	property p_cmdHold;
		@(posedge clock) disable iff (!reset_n)
		ce && cmdValid_q && !busCmdReady |=> cmdValid_q && $stable(cmd_q);
	endproperty
	a_cmdHold: assert property (p_cmdHold) else $error("command dropped");

endmodule
`default_nettype wire

/* File: testbench/mem_ctrl_model.sv */
// Memory controller model on the memory_interconnect_bus side.
// Assumes one clock shared with the cache unit; pacing set by the bench.
`timescale 1ns/10ps
`default_nettype none
module mem_ctrl_model import cache_pkg::*; (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              reset_n,
	// Pacing from the bench
	input  wire logic [7:0]        readyDelay,
	input  wire logic [7:0]        fillDelay,
	// Command side
	input  wire logic              busCmdValid,
	input  wire busCmd_t           busCmd,
	output logic                   busCmdReady,
	// Fill side
	output logic                   busFillValid,
	output logic      [DATA_W-1:0] busFillData,
	output logic      [7:0]        sizeErrs
);
	logic [DATA_W-1:0] mem [logic [PA_W-1:0]]; // Longwords written so far
	logic [7:0]        waitCnt;                // Stall counter for a command
	logic [7:0]        fillCnt;                // Latency counter for a fill
	logic              pend;                   // A read is being served
	logic [PA_W-1:0]   pendAddr;               // Address of that read

	// Stalls each command, then answers reads after a latency
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			busCmdReady <= 1'b0;
			busFillValid <= 1'b0;
			busFillData <= 32'h0;
			sizeErrs <= 8'h00;
			waitCnt <= 8'h00;
			fillCnt <= 8'h00;
			pend <= 1'b0;
			pendAddr <= 32'h0;
		end else begin
			busCmdReady <= 1'b0;
			if (busCmdValid && busCmdReady) begin
				waitCnt <= 8'h00;
				case (busCmd.size)
					SZ_RD_LONG, SZ_RD_OCTA, SZ_RD_HEX: begin
						pend <= 1'b1;
						pendAddr <= busCmd.addr;
						fillCnt <= fillDelay;
					end
					SZ_WR_LONG, SZ_WR_MQUAD, SZ_WR_OCTA: begin
						mem[busCmd.addr] = busCmd.data;
					end
					default: sizeErrs <= sizeErrs + 8'h01;
				endcase
			end else if (busCmdValid) begin
				// Slow answer when readyDelay is set
				if (waitCnt >= readyDelay)
					busCmdReady <= 1'b1;
				else
					waitCnt <= waitCnt + 8'h01;
			end
			if (pend && fillCnt == 8'h00) begin
				busFillValid <= 1'b1;
				busFillData <= mem.exists(pendAddr) ? mem[pendAddr] : ~pendAddr;
				pend <= 1'b0;
			end else begin
				// Released data lines never hold the last value
				busFillValid <= 1'b0;
				busFillData <= ~busFillData;
				if (pend)
					fillCnt <= fillCnt - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* File: testbench/processor_cache_translation_unit_tb_top.sv */
// Self-checking bench for the cache and translation unit.
// Assumes a memory controller model on the bus side, one 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module processor_cache_translation_unit_tb_top import cache_pkg::*;;
	logic clock, reset_n, ce, reqValid, tbLoadEn;   // Core side drive
	procReq_t reqIn;                                 // Request fields
	tbLoad_t tbLoadIn;                               // Translation load
	logic respValid, respFill, writeDone, retry, microtrap;
	logic [DATA_W-1:0] respData, busFillData;
	logic busCmdValid, busCmdReady, busFillValid;
	busCmd_t busCmd, lastCmd;                        // Command and last taken
	logic [7:0] readyDelay, fillDelay, sizeErrs;     // Model pacing
	logic [31:0] lastData;                           // Last read answer
	int mismatches, cmpCount, cyc;
	int nResp, nFill, nWd, nTrap, nRetry, nCmd;      // Pulses seen
	localparam logic [31:0] VA [2] = '{32'h0001_2A34, 32'h8001_2A34};
	localparam logic [22:0] PF [2] = '{23'h001234, 23'h005679};
	localparam logic [31:0] VA2 = 32'h0000_0600;
	localparam logic [22:0] PF2 = 23'h000ABC;
	localparam logic [31:0] WD = 32'hCAFE_0001;

	// Small cache keeps reset short; page bits unchanged
	cache_translation_unit #(.CACHE_BYTES(1024)) cache_translation_unit_i (
		.clock(clock), .reset_n(reset_n), .ce(ce), .reqValid(reqValid),
		.reqIn(reqIn), .tbLoadEn(tbLoadEn), .tbLoadIn(tbLoadIn),
		.respValid(respValid), .respData(respData), .respFill(respFill),
		.writeDone(writeDone), .retry(retry), .microtrap(microtrap),
		.busCmdValid(busCmdValid), .busCmd(busCmd), .busCmdReady(busCmdReady),
		.busFillValid(busFillValid), .busFillData(busFillData));

	mem_ctrl_model mem_ctrl_model_i (
		.clock(clock), .reset_n(reset_n), .readyDelay(readyDelay),
		.fillDelay(fillDelay), .busCmdValid(busCmdValid), .busCmd(busCmd),
		.busCmdReady(busCmdReady), .busFillValid(busFillValid),
		.busFillData(busFillData), .sizeErrs(sizeErrs));

	// Clock, 50 ns period
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Counts one-cycle pulses; also cuts a hang short
	always @(posedge clock) begin
		cyc++;
		if (cyc > 3000) begin
			mismatches++;
			finish_test;
		end
		if (respValid === 1'b1) begin
			nResp++;
			lastData = respData;
			if (respFill === 1'b1) nFill++;
		end
		if (writeDone === 1'b1) nWd++;
		if (retry === 1'b1) nRetry++;
		if (microtrap === 1'b1) nTrap++;
		if (busCmdValid === 1'b1 && busCmdReady === 1'b1) begin
			nCmd++;
			lastCmd = busCmd;
		end
	end

	function automatic logic [31:0] pa(input logic [22:0] f, input logic [31:0] v);
		return {f, v[8:0]};
	endfunction

	task automatic chk(input logic ok, input string msg);
		cmpCount++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	// Clear pulse counts away from the edge
	task automatic clr;
		@(negedge clock);
		{nResp, nFill, nWd, nTrap, nRetry, nCmd} = '0;
	endtask

	task automatic load(input logic [31:0] va, input logic [22:0] f, input logic v);
		@(posedge clock);
		tbLoadEn <= 1'b1;
		tbLoadIn <= '{valid: v, vaddr: va, pfn: f};
		@(posedge clock);
		tbLoadEn <= 1'b0;
	endtask

	task automatic req(input logic w, input logic [31:0] va, input logic [31:0] wd);
		@(posedge clock);
		reqValid <= 1'b1;
		reqIn <= '{write: w, vaddr: va, wdata: wd};
		@(posedge clock);
		reqValid <= 1'b0;
	endtask

	task automatic waitResp(input int n);
		for (int i = 0; i < 60 && nResp < n; i++) @(posedge clock);
	endtask

	// Missing and invalid translations trap without bus traffic
	task automatic t_trap;
		clr;
		req(1'b0, VA[0], 32'h0);
		repeat (3) @(posedge clock);
		chk(nTrap == 1 && nCmd == 0 && nResp == 0, "no trap on empty slot");
		load(VA[0], PF[0], 1'b0);
		clr;
		req(1'b0, VA[0], 32'h0);
		repeat (3) @(posedge clock);
		chk(nTrap == 1 && nCmd == 0, "invalid slot hit");
		$display("test trap done");
	endtask

	// Miss in both regions, then a hit on the first
	task automatic t_fill;
		for (int i = 0; i < 2; i++) begin
			load(VA[i], PF[i], 1'b1);
			clr;
			req(1'b0, VA[i], 32'h0);
			waitResp(1);
			chk(nCmd == 1 && lastCmd.size === SZ_RD_LONG, "bad read command");
			chk(lastCmd.addr === pa(PF[i], VA[i]), "bad physical address");
			chk(nFill == 1 && lastData === ~pa(PF[i], VA[i]), "bad fill answer");
		end
		clr;
		req(1'b0, VA[0], 32'h0);
		repeat (3) @(posedge clock);
		chk(nResp == 1 && nFill == 0 && nCmd == 0, "hit went to memory");
		chk(lastData === ~pa(PF[0], VA[0]), "filled line lost");
		$display("test fill done");
	endtask

	// Same slot, other tag bits: no hit
	task automatic t_tag;
		clr;
		req(1'b0, VA[0] | 32'h0040_0000, 32'h0);
		repeat (3) @(posedge clock);
		chk(nTrap == 1 && nCmd == 0, "tag mismatch hit");
		$display("test tag done");
	endtask

	// Stalled write goes to memory and updates the hit line
	task automatic t_write;
		readyDelay <= 8'd3;
		clr;
		req(1'b1, VA[0], WD);
		for (int i = 0; i < 40 && nCmd < 1; i++) @(posedge clock);
		chk(nWd == 1 && lastCmd.size === SZ_WR_LONG, "bad write command");
		chk(lastCmd.addr === pa(PF[0], VA[0]) && lastCmd.data === WD, "bad write");
		chk(lastCmd.mask === LONG_MASK, "bad write mask");
		readyDelay <= 8'd0;
		clr;
		req(1'b0, VA[0], 32'h0);
		repeat (3) @(posedge clock);
		chk(nResp == 1 && nCmd == 0 && lastData === WD, "cache not updated");
		$display("test write done");
	endtask

	// Slow miss: hits still served, second miss refused
	task automatic t_busy;
		fillDelay <= 8'd20;
		load(VA2, PF2, 1'b1);
		clr;
		req(1'b0, VA2, 32'h0);
		req(1'b0, VA[0], 32'h0);
		req(1'b0, VA2 + 32'h4, 32'h0);
		repeat (3) @(posedge clock);
		chk(nResp == 1 && nFill == 0 && lastData === WD, "hit blocked by miss");
		chk(nRetry == 1, "second miss not refused");
		waitResp(2);
		chk(nFill == 1 && lastData === ~pa(PF2, VA2), "slow fill wrong");
		$display("test busy done");
	endtask

	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmpCount, mismatches);
		if (mismatches == 0 && cmpCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		{mismatches, cmpCount, cyc} = '0;
		reset_n = 1'b0;
		ce = 1'b1;
		reqValid = 1'b0;
		reqIn = '0;
		tbLoadEn = 1'b0;
		tbLoadIn = '0;
		readyDelay = 8'd0;
		fillDelay = 8'd2;
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		t_trap;
		t_fill;
		t_tag;
		t_write;
		t_busy;
		chk(sizeErrs === 8'h00, "illegal bus size");
		finish_test;
	end
endmodule
`default_nettype wire
